/* File: shared/ext_bus_cfg.svh */
// constants for the external bus control block
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH

`define EB_NPIN 20
`define EB_NDMA 4
`define EB_BD_BASE 0
`define EB_WAIT 4
`define EB_CLK 5
`define EB_HGNT 6
`define EB_HREQ 7
`define EB_REFQ 8
`define EB_SELF 9
`define EB_LOW_COLUMN_STROBE 10
`define EB_HIGH_COLUMN_STROBE 11
`define EB_LWR 12
`define EB_UWR 13
`define EB_LOW_SDRAM_MASK 14
`define EB_HIGH_SDRAM_MASK 15
`define EB_RD 16
`define EB_WE 17
`define EB_OE 18
`define EB_CYCLE_START_FLAG 19
`define EB_CM_CLK 1
`define EB_CTL_IN_MASK 20'h00290
`define EB_CT_MASK 20'hffc00
`define EB_CM_BOOT 6'h2b
`define EB_MODE_SC0 2'h0
`define EB_AREA_STATIC 2'h0
`define EB_AREA_PAGE 2'h1
`define EB_AREA_DRAM 2'h2
`define EB_AREA_SDRAM 2'h3

`endif

/* File: shared/ext_bus_pkg.sv */
// shared types for the external bus control block
`include "ext_bus_cfg.svh"
package ext_bus_pkg;
    typedef enum logic [1:0] {st_idle, st_t1, st_t2, st_hold} bus_state_t;

    typedef struct packed {
        logic refresh;
        logic write;
        logic [1:0] area;
        logic [1:0] be;
        logic dbl;
        logic dma;
        logic [1:0] ch;
    } req_t;

    typedef struct packed {
        req_t req;
        logic busy;
        logic ready;
        logic req_tgl;
        logic ack_seen;
        logic done;
        logic strap_ok;
        logic [1:0] strap;
        logic stall;
        logic hold;
        logic [`EB_NPIN-1:0] port_in;
    } core_t;

    typedef struct packed {
        logic ph;
        bus_state_t st;
        req_t cur;
        logic tgl_seen;
        logic ack_tgl;
        logic more;
        logic self;
        logic hgnt;
        logic refq;
        logic cycle_start_flag;
        logic rd;
        logic we;
        logic oe;
        logic [1:0] wr;
        logic [1:0] cas;
        logic [1:0] dqm;
        logic [`EB_NDMA-1:0] grant;
        logic half_rate_bus_clock;
        logic [`EB_NPIN-1:0] pin_out;
        logic [`EB_NPIN-1:0] pin_oe;
    } link_t;
endpackage

/* File: rtl/bit_sync.sv */
// two-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        meta_r <= d;
        q <= meta_r;
    end
endmodule // bit_sync
`default_nettype wire

/* File: rtl/ext_bus_ctrl.sv */
// external bus control pins: core request side, link sequencer and pin mux
//
// Overview of operation
// - four independent DMA grant outputs, channels zero-three
// - grants only for external memory transfers
// - grant asserts at start falling edge, holds
// - per-pin port/control select and direction
// - wait sampled at T1 rise and at T2 rises while extended, inserts waits
// - wait honoured after reset in boot modes
// - single-chip zero: clock pin stays port unless selected
// - half-rate bus clock only in double cycles
// - hold: finish cycle, float bus, grant
// - hold request honoured after reset, boot modes
// - refresh request in refresh and hold
// - self-refresh stalls external accesses
// - self-refresh honoured after reset, boot modes
// - low and high column strobes, refresh too
// - write strobes from T1 fall to T2 fall
// - per-lane SDRAM mask for read and write
// - read strobe for static areas, idle inactive
// - DRAM write and output enables, idle inactive
// - cycle start flag exactly one clock
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_cfg.svh"
module ext_bus_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic [1:0] mode_strap,
    input wire logic bus_req_valid,
    output logic bus_req_ready,
    input wire logic bus_req_write,
    input wire logic [1:0] bus_req_area,
    input wire logic [1:0] bus_req_be,
    input wire logic bus_req_dbl,
    input wire logic bus_req_refresh,
    input wire logic bus_req_dma,
    input wire logic [1:0] bus_req_dma_ch,
    output logic bus_done,
    output logic ext_stall,
    output logic hold_active,
    input wire logic [3:0] bd_pin_function_select,
    input wire logic [3:0] bd_pin_direction,
    input wire logic [5:0] cm_pin_function_select,
    input wire logic cm_pin_alt_select,
    input wire logic [5:0] cm_pin_direction,
    input wire logic [9:0] ct_pin_function_select,
    input wire logic [9:0] ct_pin_direction,
    input wire logic [`EB_NPIN-1:0] port_out,
    output logic [`EB_NPIN-1:0] port_in,
    input wire logic [`EB_NPIN-1:0] pin_in,
    output logic [`EB_NPIN-1:0] pin_out,
    output logic [`EB_NPIN-1:0] pin_oe
);
    ext_bus_pkg::core_t c, c_n;
    ext_bus_pkg::link_t l, l_n;

    // core-domain view of link and pins
    logic [`EB_NPIN-1:0] s_pin;
    logic s_hold;
    logic s_self;
    logic s_ack;
    logic [1:0] s_strap;
    // link-domain view of core and pins
    logic link_rst;
    logic tgl_s;
    logic alt_s;
    logic [`EB_NPIN-1:0] pout_s;
    logic [`EB_NPIN-1:0] dir_s;
    logic [`EB_NPIN-1:0] fsel_s;
    logic [`EB_NPIN-1:0] pin_s;

    logic boot;
    logic [5:0] cm_eff;
    logic [`EB_NPIN-1:0] fsel_all;
    logic [`EB_NPIN-1:0] dir_all;

    bit_sync #(.W(`EB_NPIN + 5)) u_core_sync (
        .clk(clk),
        .d({pin_in, l.hgnt, l.self, l.ack_tgl, mode_strap}),
        .q({s_pin, s_hold, s_self, s_ack, s_strap})
    );

    // boot modes hand wait, clock, hold request and self-refresh to the pins
    assign boot = c.strap_ok && (c.strap != `EB_MODE_SC0);
    assign cm_eff = cm_pin_function_select | (boot ? `EB_CM_BOOT : 6'h00);
    assign fsel_all = {ct_pin_function_select, cm_eff, bd_pin_function_select};
    assign dir_all = {ct_pin_direction, cm_pin_direction, bd_pin_direction};

    bit_sync #(.W(4 * `EB_NPIN + 3)) u_link_sync (
        .clk(link_clk),
        .d({srst, c.req_tgl, cm_pin_alt_select, port_out, dir_all, fsel_all, pin_in}),
        .q({link_rst, tgl_s, alt_s, pout_s, dir_s, fsel_s, pin_s})
    );

    // core side: one request in flight, handed over by toggle
    always_comb begin
        c_n = c;
        c_n.done = 1'b0;
        c_n.port_in = s_pin;
        c_n.hold = s_hold;
        c_n.stall = s_self;
        if (!c.strap_ok) begin
            c_n.strap = s_strap;
            c_n.strap_ok = 1'b1;
        end
        if (c.ready && bus_req_valid) begin
            c_n.req.refresh = bus_req_refresh;
            c_n.req.write = bus_req_write;
            c_n.req.area = bus_req_area;
            c_n.req.be = bus_req_be;
            c_n.req.dbl = bus_req_dbl;
            c_n.req.dma = bus_req_dma;
            c_n.req.ch = bus_req_dma_ch;
            c_n.busy = 1'b1;
            c_n.req_tgl = !c.req_tgl;
        end
        if (s_ack != c.ack_seen) begin
            c_n.ack_seen = s_ack;
            c_n.busy = 1'b0;
            c_n.done = 1'b1;
        end
        c_n.ready = !c_n.busy && !c_n.stall;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            c <= '0;
        end else begin
            c <= c_n;
        end
    end

    assign bus_req_ready = c.ready;
    assign bus_done = c.done;
    assign ext_stall = c.stall;
    assign hold_active = c.hold;
    assign port_in = c.port_in;

    // link side
    logic pend;
    logic wait_act;
    logic hold_act;
    logic in_cyc;
    logic static_wr;
    logic [1:0] lane_wr;
    logic [1:0] lane_cas;
    logic [1:0] lane_dqm;
    logic [`EB_NPIN-1:0] ctl_v;
    logic [`EB_NPIN-1:0] ctl_oe;
    logic [`EB_NPIN-1:0] mux_out;
    logic [`EB_NPIN-1:0] mux_oe;

    assign pend = (tgl_s != l.tgl_seen);
    assign wait_act = fsel_s[`EB_WAIT] && !pin_s[`EB_WAIT];
    assign hold_act = fsel_s[`EB_HREQ] && !pin_s[`EB_HREQ];
    assign in_cyc = (l.st == ext_bus_pkg::st_t1) || (l.st == ext_bus_pkg::st_t2);
    assign static_wr = l.cur.write && !l.cur.refresh && (l.cur.area == `EB_AREA_STATIC);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            assign lane_wr[gi] = static_wr && l.cur.be[gi] && ((l.st == ext_bus_pkg::st_t1)
                || (l.st == ext_bus_pkg::st_t2 && l.more));
            assign lane_cas[gi] = (l.st == ext_bus_pkg::st_t2) && (l.cur.refresh
                || (l.cur.area == `EB_AREA_DRAM && l.cur.be[gi]));
            assign lane_dqm[gi] = !(in_cyc && !l.cur.refresh
                && l.cur.area == `EB_AREA_SDRAM && l.cur.be[gi]);
        end
        for (gi = 0; gi < `EB_NPIN; gi++) begin : g_pin
            assign mux_out[gi] = fsel_s[gi] ? ctl_v[gi] : pout_s[gi];
            assign mux_oe[gi] = fsel_s[gi] ? ctl_oe[gi] : dir_s[gi];
        end
    endgenerate

    // pin levels: strobes, grants and requests are active low
    assign ctl_v[`EB_BD_BASE +: `EB_NDMA] = ~l.grant;
    assign ctl_v[`EB_WAIT] = 1'b1;
    assign ctl_v[`EB_CLK] = alt_s ? l.half_rate_bus_clock : l.ph;
    assign ctl_v[`EB_HGNT] = !l.hgnt;
    assign ctl_v[`EB_HREQ] = 1'b1;
    assign ctl_v[`EB_REFQ] = !l.refq;
    assign ctl_v[`EB_SELF] = 1'b1;
    assign ctl_v[`EB_LOW_COLUMN_STROBE] = !l.cas[0];
    assign ctl_v[`EB_HIGH_COLUMN_STROBE] = !l.cas[1];
    assign ctl_v[`EB_LWR] = !l.wr[0];
    assign ctl_v[`EB_UWR] = !l.wr[1];
    assign ctl_v[`EB_LOW_SDRAM_MASK] = l.dqm[0];
    assign ctl_v[`EB_HIGH_SDRAM_MASK] = l.dqm[1];
    assign ctl_v[`EB_RD] = !l.rd;
    assign ctl_v[`EB_WE] = !l.we;
    assign ctl_v[`EB_OE] = !l.oe;
    assign ctl_v[`EB_CYCLE_START_FLAG] = !l.cycle_start_flag;
    // control bus floats while the outside master owns it
    assign ctl_oe = ~`EB_CTL_IN_MASK & (l.hgnt ? ~`EB_CT_MASK : ~20'h00000);

    always_comb begin
        l_n = l;
        l_n.ph = !l.ph;
        l_n.self = fsel_s[`EB_SELF] && pin_s[`EB_SELF];
        l_n.pin_out = mux_out;
        l_n.pin_oe = mux_oe;
        if (!l.ph) begin
            // clock-out rising edge: state step and wait sampling
            unique case (l.st)
                ext_bus_pkg::st_idle: begin
                    if (hold_act) begin
                        l_n.st = ext_bus_pkg::st_hold;
                        l_n.hgnt = 1'b1;
                    end else if (pend && !l.self) begin
                        l_n.cur = c.req;
                        l_n.tgl_seen = tgl_s;
                        l_n.st = ext_bus_pkg::st_t1;
                    end
                end
                ext_bus_pkg::st_t1: begin
                    l_n.st = ext_bus_pkg::st_t2;
                    l_n.more = wait_act || l.cur.dbl;
                end
                ext_bus_pkg::st_t2: begin
                    if (l.more) begin
                        l_n.more = wait_act;
                    end else begin
                        l_n.st = ext_bus_pkg::st_idle;
                        l_n.ack_tgl = !l.ack_tgl;
                    end
                end
                ext_bus_pkg::st_hold: begin
                    if (!hold_act) begin
                        l_n.st = ext_bus_pkg::st_idle;
                        l_n.hgnt = 1'b0;
                    end
                end
            endcase
            l_n.cycle_start_flag = (l_n.st == ext_bus_pkg::st_t1);
            l_n.rd = ((l_n.st == ext_bus_pkg::st_t1) || (l_n.st == ext_bus_pkg::st_t2))
                && !l_n.cur.write && !l_n.cur.refresh && !l_n.cur.area[1];
            l_n.we = ((l_n.st == ext_bus_pkg::st_t1) || (l_n.st == ext_bus_pkg::st_t2))
                && l_n.cur.write && !l_n.cur.refresh
                && l_n.cur.area == `EB_AREA_DRAM;
            l_n.oe = ((l_n.st == ext_bus_pkg::st_t1) || (l_n.st == ext_bus_pkg::st_t2))
                && !l_n.cur.write && !l_n.cur.refresh
                && l_n.cur.area == `EB_AREA_DRAM;
        end else begin
            // clock-out falling edge: byte strobes, grants, bus clock
            l_n.wr = lane_wr;
            l_n.cas = lane_cas;
            l_n.dqm = lane_dqm;
            // only external cycles reach this sequencer
            if (l.st == ext_bus_pkg::st_t1 && l.cur.dma && !l.cur.refresh) begin
                l_n.grant[l.cur.ch] = 1'b1;
            end else if (!in_cyc) begin
                l_n.grant = '0;
            end
            l_n.half_rate_bus_clock = (in_cyc && l.cur.dbl) ? !l.half_rate_bus_clock : 1'b0;
        end
        l_n.refq = (in_cyc && l.cur.refresh)
            || (l.st == ext_bus_pkg::st_hold && pend && c.req.refresh);
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l <= '0;
        end else begin
            l <= l_n;
        end
    end

    assign pin_out = l.pin_out;
    assign pin_oe = l.pin_oe;

    // checks
    boot_pins_a: assert property (@(posedge clk) disable iff (srst)
        (c.strap_ok && c.strap != `EB_MODE_SC0) |-> ((cm_eff & `EB_CM_BOOT) == `EB_CM_BOOT))
        else $error("boot mode control pins not selected");
    sc0_clock_a: assert property (@(posedge clk) disable iff (srst)
        (c.strap_ok && c.strap == `EB_MODE_SC0 && !cm_pin_function_select[`EB_CM_CLK])
        |-> !cm_eff[`EB_CM_CLK])
        else $error("clock pin left port mode in single-chip zero");
    stall_ready_a: assert property (@(posedge clk) disable iff (srst)
        c.stall |-> !c.ready)
        else $error("request accepted during self-refresh");
    start_one_clock_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(l.cycle_start_flag) |-> l.cycle_start_flag ##1 l.cycle_start_flag ##1 !l.cycle_start_flag)
        else $error("cycle start flag not one clock long");
    idle_strobes_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (l.st == ext_bus_pkg::st_idle) |-> !(l.rd || l.we || l.oe || l.cycle_start_flag))
        else $error("strobe active in idle state");
    wr_start_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(l.wr[0]) |-> (l.st == ext_bus_pkg::st_t1) && !l.ph)
        else $error("write strobe not started at T1 fall");
    wr_end_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $fell(l.wr[0]) |-> (l.st == ext_bus_pkg::st_t2) && !l.ph)
        else $error("write strobe not ended at T2 fall");
    grant_onehot_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $onehot0(l.grant))
        else $error("more than one DMA grant active");
    grant_held_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $fell(|l.grant) |-> (l.st == ext_bus_pkg::st_idle))
        else $error("DMA grant dropped inside transfer");
    hold_entry_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (l.st == ext_bus_pkg::st_idle && !l.ph && hold_act) |=> l.hgnt)
        else $error("idle bus not handed over at once");
    hold_float_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (l.hgnt && $past(l.hgnt)) |-> ((l.pin_oe & `EB_CT_MASK) == '0))
        else $error("control bus driven during hold");
    wait_stretch_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (l.st == ext_bus_pkg::st_t1 && !l.ph && wait_act)
        |=> (l.st == ext_bus_pkg::st_t2) ##2 (l.st == ext_bus_pkg::st_t2))
        else $error("wait state not inserted");
    half_rate_bus_clock_dbl_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(l.half_rate_bus_clock) |-> l.cur.dbl && in_cyc)
        else $error("bus clock outside double-period cycle");
    refresh_hold_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (l.st == ext_bus_pkg::st_hold && pend && c.req.refresh) |=> l.refq)
        else $error("refresh request not shown during hold");
    cas_refresh_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (l.st == ext_bus_pkg::st_t2 && l.ph && l.cur.refresh) |=> (l.cas == 2'b11))
        else $error("column strobes missing in refresh cycle");
    grant_internal_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (l.st == ext_bus_pkg::st_t1 && l.ph && !l.cur.dma) |=> (l.grant == 4'h0))
        else $error("DMA grant without DMA transfer");
    rd_static_a: assert property (@(posedge link_clk) disable iff (link_rst)
        l.rd |-> (!l.cur.area[1] && !l.cur.write))
        else $error("read strobe outside static read");
    dqm_idle_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (l.st == ext_bus_pkg::st_idle && l.ph) |=> (l.dqm == 2'b11))
        else $error("SDRAM mask open in idle");

    hold_seen_c: cover property (@(posedge link_clk) disable iff (link_rst) $rose(l.hgnt));
    grant_seen_c: cover property (@(posedge link_clk) disable iff (link_rst) $rose(|l.grant));
    wait_seen_c: cover property (@(posedge link_clk) disable iff (link_rst)
        (l.st == ext_bus_pkg::st_t2 && !l.ph && l.more && wait_act));
    refresh_seen_c: cover property (@(posedge link_clk) disable iff (link_rst) $rose(l.refq));
    dbl_seen_c: cover property (@(posedge link_clk) disable iff (link_rst) $rose(l.half_rate_bus_clock));
endmodule // ext_bus_ctrl
`default_nettype wire

/* File: sim/bus_side_model.sv */
// far side model: wait source, external bus master and self-refresh input
`timescale 1ns/1ps
`default_nettype none
module bus_side_model (
    input wire logic link_clk,
    input wire logic [19:0] pin_out,
    input wire logic [19:0] pin_oe,
    input wire logic [3:0] wait_len,
    input wire logic hold_want,
    input wire logic self_want,
    output logic [19:0] pin_in
);
    logic [4:0] wait_cnt_r = 5'h00;
    logic wait_spent_r = 1'b0;
    logic hold_req_r = 1'b0;
    logic [19:0] far_drv;
    always @(posedge link_clk) begin
        if (pin_oe[19] && !pin_out[19]) begin
            wait_cnt_r <= {1'b0, wait_len};
        end else if (wait_cnt_r != 5'h00) begin
            wait_cnt_r <= wait_cnt_r - 5'h01;
        end
        // wait is held low ahead of the cycle so the first rise already sees it
        if (wait_len == 4'h0) begin
            wait_spent_r <= 1'b0;
        end else if (pin_oe[19] && !pin_out[19]) begin
            wait_spent_r <= 1'b1;
        end
        if (hold_want) begin
            hold_req_r <= 1'b1;
        end else if (pin_oe[6] && !pin_out[6]) begin
            hold_req_r <= 1'b0;
        end
    end
    // undriven lines sit at their pull-up level
    always_comb begin
        far_drv = 20'hfffff;
        far_drv[4] = (wait_cnt_r == 5'h00) && (wait_len == 4'h0 || wait_spent_r);
        far_drv[7] = !hold_req_r;
        far_drv[9] = self_want;
        pin_in = (pin_oe & pin_out) | (~pin_oe & far_drv);
    end
endmodule // bus_side_model
`default_nettype wire

/* File: sim/ext_bus_ctrl_tb.sv */
// testbench for the external bus control pins block
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ctrl_tb;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] mode_strap = 2'h0;
    logic valid = 1'b0;
    logic rq_w = 1'b0;
    logic [1:0] rq_a = 2'h0;
    logic [1:0] rq_be = 2'h0;
    logic rq_d = 1'b0;
    logic rq_rf = 1'b0;
    logic rq_dm = 1'b0;
    logic [1:0] rq_ch = 2'h0;
    logic [3:0] bd_sel = 4'hf;
    logic [3:0] bd_dir = 4'h0;
    logic [5:0] cm_sel = 6'h00;
    logic [19:0] port_out = 20'h00000;
    logic [3:0] wait_len = 4'h0;
    logic hold_want = 1'b0;
    logic self_want = 1'b0;
    logic mon_clr = 1'b0;
    logic last5 = 1'b0;
    logic ready, done, stall, held;
    logic [19:0] port_in, pin_in, pin_out, pin_oe;
    int cnt [20];
    int tog5 = 0;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    ext_bus_ctrl dut (.clk(clk), .srst(srst), .link_clk(link_clk), .mode_strap(mode_strap),
        .bus_req_valid(valid), .bus_req_ready(ready), .bus_req_write(rq_w), .bus_req_area(rq_a),
        .bus_req_be(rq_be), .bus_req_dbl(rq_d), .bus_req_refresh(rq_rf), .bus_req_dma(rq_dm),
        .bus_req_dma_ch(rq_ch), .bus_done(done), .ext_stall(stall), .hold_active(held),
        .bd_pin_function_select(bd_sel), .bd_pin_direction(bd_dir),
        .cm_pin_function_select(cm_sel), .cm_pin_alt_select(1'b1), .cm_pin_direction(6'h00),
        .ct_pin_function_select(10'h3ff), .ct_pin_direction(10'h000), .port_out(port_out),
        .port_in(port_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    bus_side_model far_side (.link_clk(link_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .wait_len(wait_len), .hold_want(hold_want), .self_want(self_want), .pin_in(pin_in));
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // link cycles each pin spends at its active level, and bus clock edges
    always @(posedge link_clk) begin
        last5 <= pin_out[5];
        if (mon_clr) begin
            foreach (cnt[i]) cnt[i] <= 0;
            tog5 <= 0;
        end else begin
            for (int i = 0; i < 20; i++)
                if (pin_oe[i] && (pin_out[i] == (i == 9 || i == 14 || i == 15))) cnt[i] <= cnt[i] + 1;
            if (pin_oe[5] && pin_out[5] != last5) tog5 <= tog5 + 1;
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_cnt(input string what, input int exp, input int seen);
        checks_done++;
        if (seen != exp) begin
            bad_count++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int seen);
        checks_done++;
        if (seen < lo || seen > hi) begin
            bad_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, seen);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %b, seen %b", what, exp, seen);
        end
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return held;
            1: return stall;
            2: return ready;
            default: return done;
        endcase
    endfunction
    // bounded wait for a flag, sampled on the falling edge of clk, away from its rising edge
    task automatic await(input int which, input logic lvl, input string what);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pick(which) !== lvl && n < 400);
        chk_bit(what, lvl, pick(which));
    endtask
    task automatic take(input logic w, input logic [1:0] a, input logic [1:0] be, input logic d,
                        input logic rf, input logic dm, input logic [1:0] ch);
        @(posedge clk);
        mon_clr <= 1'b1;
        @(posedge clk);
        rq_w <= w;
        rq_a <= a;
        rq_be <= be;
        rq_d <= d;
        rq_rf <= rf;
        rq_dm <= dm;
        rq_ch <= ch;
        valid <= 1'b1;
        await(2, 1'b1, "ready");
        @(posedge clk);
        valid <= 1'b0;
        mon_clr <= 1'b0;
    endtask
    task automatic scen(input logic w, input logic [1:0] a, input logic [1:0] be, input logic d,
                        input logic rf, input logic dm, input logic [1:0] ch, input int wt);
        int n2;
        int strobe;
        n2 = 1 + d;
        strobe = rf ? 0 : 2 * (1 + n2);
        wait_len <= wt[3:0];
        take(w, a, be, d, rf, dm, ch);
        await(3, 1'b1, "done");
        wait_len <= 4'h0;
        repeat (4) @(negedge clk);
        chk_cnt("start flag", 2, cnt[19]);
        chk_cnt("low write", (w && a == 2'h0 && be[0]) ? 2 * n2 : 0, cnt[12]);
        chk_cnt("high write", (w && a == 2'h0 && be[1]) ? 2 * n2 : 0, cnt[13]);
        if (wt == 0) chk_cnt("read", (!w && !rf && a < 2'h2) ? strobe : 0, cnt[16]);
        else chk_rng("read", strobe + 2, strobe + 4 * wt, cnt[16]);
        chk_cnt("dram write", (w && a == 2'h2 && !rf) ? strobe : 0, cnt[17]);
        chk_cnt("dram read", (!w && a == 2'h2 && !rf) ? strobe : 0, cnt[18]);
        chk_bit("column strobes", a == 2'h2, cnt[10] > 0 && cnt[11] > 0);
        chk_bit("refresh request", rf, cnt[8] > 0);
        if (a == 2'h3) chk_bit("lane mask", 1'b1, cnt[15] > cnt[14]);
        for (int k = 0; k < 4; k++)
            chk_cnt("dma grant", (dm && ch == k) ? 2 * n2 + 2 : 0, cnt[k]);
        chk_bit("bus clock", d, tog5 > 0);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(negedge clk);
        chk_bit("clock pin drive", 1'b0, pin_oe[5]);
        @(posedge clk);
        cm_sel <= 6'h3f;
        bd_sel <= 4'h0;
        bd_dir <= 4'h5;
        port_out <= 20'h00005;
        repeat (10) @(negedge clk);
        chk_bit("clock pin drive", 1'b1, pin_oe[5]);
        chk_bit("port drive", 1'b1, pin_oe[3:0] === 4'h5 && pin_out[0] && pin_out[2]);
        chk_bit("port input", 1'b1, port_in[1]);
        @(posedge clk);
        bd_sel <= 4'hf;
        bd_dir <= 4'h0;
        repeat (10) @(posedge clk);
        scen(1'b1, 2'h0, 2'h1, 1'b0, 1'b0, 1'b1, 2'h2, 0);
        scen(1'b1, 2'h0, 2'h2, 1'b1, 1'b0, 1'b1, 2'h3, 0);
        scen(1'b0, 2'h1, 2'h3, 1'b0, 1'b0, 1'b1, 2'h0, 0);
        scen(1'b1, 2'h2, 2'h3, 1'b0, 1'b0, 1'b1, 2'h1, 0);
        scen(1'b0, 2'h2, 2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 0);
        scen(1'b1, 2'h3, 2'h1, 1'b0, 1'b0, 1'b0, 2'h0, 0);
        scen(1'b0, 2'h2, 2'h3, 1'b0, 1'b1, 1'b0, 2'h0, 0);
        scen(1'b0, 2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 2);
        @(posedge clk);
        hold_want <= 1'b1;
        await(0, 1'b1, "hold active");
        repeat (4) @(negedge clk);
        chk_bit("hold grant", 1'b0, pin_out[6]);
        chk_bit("bus floated", 1'b1, pin_oe[19:10] == 10'h000);
        take(1'b0, 2'h2, 2'h3, 1'b0, 1'b1, 1'b0, 2'h0);
        repeat (60) @(negedge clk);
        chk_bit("refresh in hold", 1'b1, cnt[8] > 0);
        chk_cnt("start in hold", 0, cnt[19]);
        @(posedge clk);
        hold_want <= 1'b0;
        await(3, 1'b1, "done after hold");
        await(0, 1'b0, "hold active");
        @(posedge clk);
        self_want <= 1'b1;
        await(1, 1'b1, "stall");
        await(2, 1'b0, "ready");
        @(posedge clk);
        self_want <= 1'b0;
        await(1, 1'b0, "stall");
        @(posedge clk);
        srst <= 1'b1;
        mode_strap <= 2'h1;
        cm_sel <= 6'h04;
        hold_want <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        await(0, 1'b1, "hold after reset");
        @(posedge clk);
        hold_want <= 1'b0;
        await(0, 1'b0, "hold after reset");
        @(posedge clk);
        self_want <= 1'b1;
        await(1, 1'b1, "stall after reset");
        @(posedge clk);
        self_want <= 1'b0;
        await(1, 1'b0, "stall after reset");
        scen(1'b0, 2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 2);
        wrap_up();
    end
endmodule // ext_bus_ctrl_tb
`default_nettype wire
